// [rtl/gpg_pkg.sv]
/*
 Package for the eight-pin port group: register indices, field layout,
 sense codes and the carrier structs shared by the port group design.
 Assumes a 32-bit APB with one register per aligned word.
*/
package gpg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_DRIVE_ENABLE     = 6'h00;
  localparam logic [5:0] IDX_DRIVE_ENABLE_SET = 6'h01;
  localparam logic [5:0] IDX_DRIVE_ENABLE_CLR = 6'h02;
  localparam logic [5:0] IDX_DRIVE_ENABLE_TGL = 6'h03;
  localparam logic [5:0] IDX_DRIVE_LEVEL      = 6'h04;
  localparam logic [5:0] IDX_DRIVE_LEVEL_SET  = 6'h05;
  localparam logic [5:0] IDX_DRIVE_LEVEL_CLR  = 6'h06;
  localparam logic [5:0] IDX_DRIVE_LEVEL_TGL  = 6'h07;
  localparam logic [5:0] IDX_SAMPLED_LEVEL    = 6'h08;
  localparam logic [5:0] IDX_PIN_EVENT_FLAGS  = 6'h09;
  localparam logic [5:0] IDX_GROUP_CONTROL    = 6'h0a;
  localparam logic [5:0] IDX_CONFIG_TEMPLATE  = 6'h0b;
  localparam logic [5:0] IDX_TEMPLATE_COPY    = 6'h0c;
  localparam logic [5:0] IDX_TEMPLATE_OR      = 6'h0d;
  localparam logic [5:0] IDX_TEMPLATE_ANDNOT  = 6'h0e;
  localparam logic [5:0] IDX_LINE_CONTROL     = 6'h10;
  localparam logic [5:0] IDX_EVENT_SELECT     = 6'h18;
  localparam logic [5:0] IDX_ALIAS_ENABLE     = 6'h20;
  localparam logic [5:0] IDX_ALIAS_LEVEL      = 6'h21;
  localparam logic [5:0] IDX_ALIAS_SAMPLED    = 6'h22;
  localparam logic [5:0] IDX_ALIAS_FLAGS      = 6'h23;

  // Field positions
  localparam int EDGE_RATE_BIT = 0;
  localparam int EVT0_LSB      = 0;
  localparam int EVT1_LSB      = 4;

  // Reset values and writable-bit masks
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [7:0] LINE_MASK    = 8'hcf;
  localparam logic [7:0] EVT_SEL_MASK = 8'h77;

  // Sense codes
  typedef enum logic [2:0] {
    SENSE_OFF     = 3'h0,
    SENSE_BOTH    = 3'h1,
    SENSE_RISE    = 3'h2,
    SENSE_FALL    = 3'h3,
    SENSE_BUF_OFF = 3'h4,
    SENSE_LOW     = 3'h5
  } gpg_sense_type;

  // Per-pin control byte
  typedef struct packed {
    logic       polarity_flip;
    logic       threshold_select;
    logic [1:0] unused;
    logic       weak_high_enable;
    logic [2:0] sense_config;
  } gpg_line_type;

  // Pad controls, one bit per pin, plus one slew limit bit for the group
  typedef struct packed {
    logic [7:0] drive_en;
    logic [7:0] level;
    logic [7:0] pull_en;
    logic [7:0] ttl_sel;
    logic [7:0] ibuf_en;
    logic       slew_limit;
  } gpg_pad_type;

endpackage

// [rtl/gpg_port_group.sv]
/*
 Eight-pin general purpose I/O port group with an APB register slave.
 Assumes pads that take the gpg_pad_type controls, a pin_in that may be
 asynchronous to pclk, and a system that links the template of all groups.
*/
`timescale 1ns/100ps
module gpg_port_group
  import gpg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PINS   = 8
) (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pins
  input  wire logic [PINS-1:0]   pin_in,
  output gpg_pad_type            pad,
  // Shared template link
  input  wire logic              tmpl_ext_wr,
  input  wire logic [7:0]        tmpl_ext_data,
  output logic                   tmpl_wr,
  output logic [7:0]             tmpl_data,
  // Requests and events
  output logic                   port_irq,
  output logic                   wake_req,
  output logic [1:0]             level_event
);

  logic [7:0]   drive_enable_reg;
  logic [7:0]   drive_level_reg;
  logic [7:0]   sampled_level_reg;
  logic [7:0]   sync_first_reg;
  logic [7:0]   sampled_prev_reg;
  logic [7:0]   pin_event_flags_reg;
  logic [7:0]   group_control_reg;
  logic [7:0]   config_template_reg;
  logic [7:0]   event_select_reg;
  gpg_line_type line_reg [8];
  logic [31:0]  prdata_reg;
  logic         pslverr_reg;

  logic         setup;
  logic         wr;
  logic [5:0]   idx;
  logic [7:0]   wb;
  logic [7:0]   polarity;
  logic [7:0]   ibuf_on;
  logic [7:0]   sense_on;
  logic [7:0]   internal;
  logic [7:0]   hit;
  logic [7:0]   rd_byte;
  logic [7:0]   pull_on;
  logic [7:0]   ttl_on;

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i <= IDX_TEMPLATE_ANDNOT) ||
                (i >= IDX_LINE_CONTROL && i <= IDX_EVENT_SELECT) ||
                (i >= IDX_ALIAS_ENABLE && i <= IDX_ALIAS_FLAGS);
  endfunction

  function automatic logic wr_to(input logic [5:0] i, input logic [5:0] a,
                                input logic [5:0] b);
    wr_to = (i == a) || (i == b);
  endfunction

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign idx    = paddr[7:2];
  assign wb     = pwdata[7:0];
  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  // Per-pin decode of line control
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      polarity[n] = line_reg[n].polarity_flip;
      ibuf_on[n]  = line_reg[n].sense_config != SENSE_BUF_OFF;
      sense_on[n] = line_reg[n].sense_config != SENSE_OFF &&
                    line_reg[n].sense_config != SENSE_BUF_OFF;
      pull_on[n] = line_reg[n].weak_high_enable &&
                   !drive_enable_reg[n];
      ttl_on[n]  = line_reg[n].threshold_select;
    end
  end

  // Pad side; the pad threshold governs every consumer of pin_in
  assign internal       = pin_in[7:0] ^ polarity;
  assign pad.drive_en   = drive_enable_reg;
  assign pad.level      = drive_level_reg ^ polarity;
  assign pad.ibuf_en    = ibuf_on;
  assign pad.pull_en    = pull_on;
  assign pad.ttl_sel    = ttl_on;
  assign pad.slew_limit = group_control_reg[EDGE_RATE_BIT];

  // Template link; a local write strobes tmpl_wr, but tmpl_data still carries the template held before that write
  assign tmpl_wr   = wr && idx == IDX_CONFIG_TEMPLATE;
  assign tmpl_data = config_template_reg;

  // Sense decision per pin, from the synchronised stream
  always_comb begin
    hit = 8'h00;
    for (int n = 0; n < 8; n++) begin
      unique case (line_reg[n].sense_config)
        SENSE_BOTH: hit[n] = sampled_level_reg[n] ^ sampled_prev_reg[n];
        SENSE_RISE: hit[n] = sampled_level_reg[n] & ~sampled_prev_reg[n];
        SENSE_FALL: hit[n] = ~sampled_level_reg[n] & sampled_prev_reg[n];
        SENSE_LOW:  hit[n] = ~sampled_level_reg[n];
        default:    hit[n] = 1'b0;
      endcase
    end
  end

  // Clock-free path: pin differs from its last sample, or sits low
  always_comb begin
    wake_req = 1'b0;
    for (int n = 0; n < 8; n++) begin
      if (sense_on[n] && (line_reg[n].sense_config == SENSE_LOW ?
          !internal[n] : internal[n] != sampled_level_reg[n])) begin
        wake_req = 1'b1;
      end
    end
  end

  assign port_irq = |(pin_event_flags_reg & sense_on);

  // Event outputs follow the pin directly, zero while buffer is off
  assign level_event[0] =
    ibuf_on[event_select_reg[EVT0_LSB +: 3]] &&
    internal[event_select_reg[EVT0_LSB +: 3]];
  assign level_event[1] =
    ibuf_on[event_select_reg[EVT1_LSB +: 3]] &&
    internal[event_select_reg[EVT1_LSB +: 3]];

  // Direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_enable_reg <= BYTE_RESET;
    end else if (wr) begin
      if (wr_to(idx, IDX_DRIVE_ENABLE, IDX_ALIAS_ENABLE)) begin
        drive_enable_reg <= wb;
      end else if (idx == IDX_DRIVE_ENABLE_SET) begin
        drive_enable_reg <= drive_enable_reg | wb;
      end else if (idx == IDX_DRIVE_ENABLE_CLR) begin
        drive_enable_reg <= drive_enable_reg & ~wb;
      end else if (idx == IDX_DRIVE_ENABLE_TGL) begin
        drive_enable_reg <= drive_enable_reg ^ wb;
      end
    end
  end

  // Output level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_level_reg <= BYTE_RESET;
    end else if (wr) begin
      if (wr_to(idx, IDX_DRIVE_LEVEL, IDX_ALIAS_LEVEL)) begin
        drive_level_reg <= wb;
      end else if (idx == IDX_DRIVE_LEVEL_SET) begin
        drive_level_reg <= drive_level_reg | wb;
      end else if (idx == IDX_DRIVE_LEVEL_CLR) begin
        drive_level_reg <= drive_level_reg & ~wb;
      end else if (idx == IDX_DRIVE_LEVEL_TGL ||
                   wr_to(idx, IDX_SAMPLED_LEVEL, IDX_ALIAS_SAMPLED)) begin
        drive_level_reg <= drive_level_reg ^ wb;
      end
    end
  end

  // Input synchroniser; a frozen pin holds both stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first_reg    <= BYTE_RESET;
      sampled_level_reg <= BYTE_RESET;
      sampled_prev_reg  <= BYTE_RESET;
    end else begin
      for (int n = 0; n < 8; n++) begin
        if (ibuf_on[n]) begin
          sync_first_reg[n]    <= internal[n];
          sampled_level_reg[n] <= sync_first_reg[n];
          sampled_prev_reg[n]  <= sampled_level_reg[n];
        end
      end
    end
  end

  // Event flags; a new hit wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_event_flags_reg <= BYTE_RESET;
    end else if (wr && wr_to(idx, IDX_PIN_EVENT_FLAGS, IDX_ALIAS_FLAGS)) begin
      pin_event_flags_reg <= (pin_event_flags_reg & ~wb) | hit;
    end else begin
      pin_event_flags_reg <= pin_event_flags_reg | hit;
    end
  end

  // Group control and event selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_control_reg <= BYTE_RESET;
      event_select_reg  <= BYTE_RESET;
    end else if (wr) begin
      if (idx == IDX_GROUP_CONTROL) begin
        group_control_reg <= wb & 8'h01;
      end
      if (idx == IDX_EVENT_SELECT) begin
        event_select_reg <= wb & EVT_SEL_MASK;
      end
    end
  end

  // Shared template; either a local or a mirrored write loads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_template_reg <= BYTE_RESET;
    end else if (tmpl_wr) begin
      config_template_reg <= wb & LINE_MASK;
    end else if (tmpl_ext_wr) begin
      config_template_reg <= tmpl_ext_data & LINE_MASK;
    end
  end

  // Line controls: direct writes and template strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < 8; n++) begin
        line_reg[n] <= gpg_line_type'(BYTE_RESET);
      end
    end else if (wr) begin
      for (int n = 0; n < 8; n++) begin
        if (idx == IDX_LINE_CONTROL + 6'(n)) begin
          line_reg[n] <= gpg_line_type'(wb & LINE_MASK);
        end else if (idx == IDX_TEMPLATE_COPY && wb[n]) begin
          line_reg[n] <= gpg_line_type'(config_template_reg);
        end else if (idx == IDX_TEMPLATE_OR && wb[n]) begin
          line_reg[n] <= gpg_line_type'(line_reg[n] |
                                        config_template_reg);
        end else if (idx == IDX_TEMPLATE_ANDNOT && wb[n]) begin
          line_reg[n] <= gpg_line_type'(line_reg[n] &
                                        ~config_template_reg);
        end
      end
    end
  end

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_DRIVE_ENABLE, IDX_ALIAS_ENABLE: rd_byte = drive_enable_reg;
      IDX_DRIVE_LEVEL, IDX_ALIAS_LEVEL:   rd_byte = drive_level_reg;
      IDX_SAMPLED_LEVEL, IDX_ALIAS_SAMPLED: rd_byte = sampled_level_reg;
      IDX_PIN_EVENT_FLAGS, IDX_ALIAS_FLAGS: rd_byte = pin_event_flags_reg;
      IDX_GROUP_CONTROL:   rd_byte = group_control_reg;
      IDX_CONFIG_TEMPLATE: rd_byte = config_template_reg;
      IDX_EVENT_SELECT:    rd_byte = event_select_reg;
      default: begin
        if (idx >= IDX_LINE_CONTROL && idx < IDX_EVENT_SELECT) begin
          rd_byte = line_reg[idx[2:0]];
        end
      end
    endcase
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg  <= {24'h0, rd_byte};
      pslverr_reg <= !is_mapped(idx) || paddr[1:0] != 2'h0 ||
                     paddr[ADDR_W-1:8] != '0;
    end
  end

  a_enable_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_DRIVE_ENABLE_SET |=>
    drive_enable_reg == ($past(drive_enable_reg) | $past(wb)))
    else $error("enable set strobe wrong");
  a_enable_tgl: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_DRIVE_ENABLE_TGL |=>
    drive_enable_reg == ($past(drive_enable_reg) ^ $past(wb)))
    else $error("enable toggle wrong");
  a_level_clr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_DRIVE_LEVEL_CLR |=>
    (drive_level_reg & $past(wb)) == 8'h00)
    else $error("level clear left a bit set");
  a_sampled_tgl: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_SAMPLED_LEVEL |=>
    drive_level_reg == ($past(drive_level_reg) ^ $past(wb)))
    else $error("sampled write did not toggle level");
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    ibuf_on[0] [*3] |-> sampled_level_reg[0] == $past(internal[0], 2))
    else $error("sampled level not two cycles behind pin");
  a_buf_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !ibuf_on[1] |=> $stable(sampled_level_reg[1]))
    else $error("frozen pin sample changed");
  a_pullup_out: assert property (@(posedge pclk) disable iff (!presetn)
    drive_enable_reg[2] |-> !pad.pull_en[2])
    else $error("pull-up on while driving");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    hit[3] |=> pin_event_flags_reg[3])
    else $error("sensed event lost");
  a_tmpl_copy: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_TEMPLATE_COPY && wb[4] |=>
    line_reg[4] == $past(config_template_reg))
    else $error("template copy missed");
  a_tmpl_or: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_TEMPLATE_OR && wb[5] |=>
    line_reg[5] == ($past(line_reg[5]) | $past(config_template_reg)))
    else $error("template or wrong");
  a_out_invert: assert property (@(posedge pclk) disable iff (!presetn)
    pad.level[6] == (drive_level_reg[6] ^ line_reg[6].polarity_flip))
    else $error("output polarity wrong");
  a_event_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !ibuf_on[event_select_reg[2:0]] |-> !level_event[0])
    else $error("event high with buffer off");
  a_enable_clr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_DRIVE_ENABLE_CLR |=>
    drive_enable_reg == ($past(drive_enable_reg) & ~$past(wb)))
    else $error("enable clear strobe wrong");
  a_level_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_DRIVE_LEVEL_SET |=>
    drive_level_reg == ($past(drive_level_reg) | $past(wb)))
    else $error("level set strobe wrong");
  a_tmpl_andnot: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_TEMPLATE_ANDNOT && wb[0] |=>
    line_reg[0] == ($past(line_reg[0]) & ~$past(config_template_reg)))
    else $error("template and-not wrong");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == IDX_PIN_EVENT_FLAGS && wb[3] && !hit[3] |=>
    !pin_event_flags_reg[3])
    else $error("flag clear ignored");
  a_wake_low: assert property (@(posedge pclk) disable iff (!presetn)
    line_reg[3].sense_config == SENSE_LOW && !internal[3] |-> wake_req)
    else $error("low level gave no wake request");

endmodule

// [verification/gpg_pin_model.sv]
/*
 Board-side model of the eight port pins: a driven pin shows the pad level,
 an undriven one the pull-up or the board signal.
 Assumes the board signal is always driven by the bench.
*/
`timescale 1ns/100ps
module gpg_pin_model (
  // Pad side
  input  wire logic [7:0] drive_en,
  input  wire logic [7:0] level,
  input  wire logic [7:0] pull_en,
  // Board side
  input  wire logic [7:0] board,
  output logic [7:0]      pin_in
);
  // Driver wins over pull-up, pull-up over the board line
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin_in[n] = drive_en[n] ? level[n] : (pull_en[n] | board[n]);
    end
  end
endmodule

// [verification/gpg_tb.sv]
/*
 Self-checking bench for the port group: APB register tasks, one task per
 scenario, and the pin model on the pads.
 Assumes the zero-wait APB slave and map of the design package.
*/
`timescale 1ns/100ps
module tb;
  import gpg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0]  pin_in, board, tmpl_ext_data, tmpl_data;
  logic        tmpl_ext_wr, tmpl_wr, port_irq, wake_req, rerr, twr;
  logic [1:0]  level_event;
  gpg_pad_type pad;
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #25 pclk = ~pclk;

  gpg_port_group dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pad(pad), .tmpl_ext_wr(tmpl_ext_wr), .tmpl_ext_data(tmpl_ext_data),
    .tmpl_wr(tmpl_wr), .tmpl_data(tmpl_data), .port_irq(port_irq),
    .wake_req(wake_req), .level_event(level_event));
  gpg_pin_model pins (.drive_en(pad.drive_en), .level(pad.level),
    .pull_en(pad.pull_en), .board(board), .pin_in(pin_in));

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Waits for pready; only the watchdog ends a stall
  task automatic apb(input logic [5:0] idx, input logic wr,
                     input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {4'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    twr = tmpl_wr;
    // Zero wait states expected
    chk(8'(n), 8'h01);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    apb(idx, 1'b0, 8'h00);
    chk(rdata[7:0], e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_dir;
    wr(IDX_DRIVE_ENABLE_SET, 8'h0f);
    rd(IDX_DRIVE_ENABLE, 8'h0f);
    wr(IDX_DRIVE_ENABLE_CLR, 8'h03);
    rd(IDX_DRIVE_ENABLE, 8'h0c);
    wr(IDX_DRIVE_ENABLE_TGL, 8'hff);
    rd(IDX_DRIVE_ENABLE, 8'hf3);
    chk(pad.drive_en, 8'hf3);
    wr(IDX_ALIAS_ENABLE, 8'h55);
    rd(IDX_DRIVE_ENABLE, 8'h55);
    rd(IDX_ALIAS_ENABLE, 8'h55);
    wr(IDX_DRIVE_ENABLE, 8'h00);
  endtask

  task automatic t_level;
    wr(IDX_DRIVE_LEVEL_SET, 8'ha5);
    rd(IDX_DRIVE_LEVEL, 8'ha5);
    wr(IDX_DRIVE_LEVEL_CLR, 8'h05);
    rd(IDX_DRIVE_LEVEL, 8'ha0);
    wr(IDX_DRIVE_LEVEL_TGL, 8'h0f);
    rd(IDX_DRIVE_LEVEL, 8'haf);
    wr(IDX_SAMPLED_LEVEL, 8'h01);
    rd(IDX_ALIAS_LEVEL, 8'hae);
    chk(pad.level, 8'hae);
  endtask

  // Pin 0 inverted while driven: pad shows 1, sample reads back 0
  task automatic t_input;
    board <= 8'h3c;
    wt(4);
    rd(IDX_SAMPLED_LEVEL, 8'h3c);
    wr(IDX_DRIVE_ENABLE, 8'hff);
    wt(4);
    rd(IDX_SAMPLED_LEVEL, 8'hae);
    wr(IDX_LINE_CONTROL, 8'h80);
    // Register updates land after the access edge
    wt(1);
    chk(pad.level, 8'haf);
    wt(4);
    rd(IDX_SAMPLED_LEVEL, 8'hae);
    wr(IDX_LINE_CONTROL, 8'h00);
    wr(IDX_DRIVE_ENABLE, 8'h00);
  endtask

  task automatic t_bufoff;
    wr(IDX_EVENT_SELECT, 8'h51);
    board <= 8'h22;
    wt(4);
    chk({6'h0, level_event}, 8'h03);
    wr(IDX_LINE_CONTROL + 6'h01, 8'h04);
    wt(1);
    chk(pad.ibuf_en, 8'hfd);
    chk({6'h0, level_event}, 8'h02);
    board <= 8'h20;
    wt(4);
    rd(IDX_SAMPLED_LEVEL, 8'h22);
    wr(IDX_LINE_CONTROL + 6'h01, 8'h00);
  endtask

  task automatic t_lines;
    for (int n = 0; n < 8; n++) wr(IDX_LINE_CONTROL + 6'(n), 8'h48 + 8'(n));
    for (int n = 0; n < 8; n++) begin
      rd(IDX_LINE_CONTROL + 6'(n), 8'h48 + 8'(n));
    end
    chk(pad.ttl_sel, 8'hff);
    chk(pad.pull_en, 8'hff);
    wr(IDX_DRIVE_ENABLE, 8'h0f);
    wt(1);
    chk(pad.pull_en, 8'hf0);
    wr(IDX_DRIVE_ENABLE, 8'h00);
    wr(IDX_LINE_CONTROL, 8'hff);
    rd(IDX_LINE_CONTROL, LINE_MASK);
    wr(IDX_GROUP_CONTROL, 8'h01);
    wt(1);
    chk({7'h0, pad.slew_limit}, 8'h01);
    apb(6'h0f, 1'b0, 8'h00);
    chk({7'h0, rerr}, 8'h01);
  endtask

  task automatic t_tmpl;
    wr(IDX_CONFIG_TEMPLATE, 8'h88);
    chk({7'h0, twr}, 8'h01);
    wr(IDX_TEMPLATE_COPY, 8'hff);
    chk({7'h0, twr}, 8'h00);
    for (int n = 0; n < 8; n++) rd(IDX_LINE_CONTROL + 6'(n), 8'h88);
    wr(IDX_CONFIG_TEMPLATE, 8'h41);
    wr(IDX_TEMPLATE_OR, 8'h03);
    rd(IDX_LINE_CONTROL + 6'h01, 8'hc9);
    rd(IDX_LINE_CONTROL + 6'h02, 8'h88);
    wr(IDX_CONFIG_TEMPLATE, 8'h80);
    wr(IDX_TEMPLATE_ANDNOT, 8'h01);
    rd(IDX_LINE_CONTROL, 8'h49);
    rd(IDX_LINE_CONTROL + 6'h01, 8'hc9);
    chk(tmpl_data, 8'h80);
    tmpl_ext_wr <= 1'b1;
    tmpl_ext_data <= 8'h00;
    wt(1);
    tmpl_ext_wr <= 1'b0;
    wr(IDX_TEMPLATE_COPY, 8'hff);
    rd(IDX_LINE_CONTROL + 6'h01, 8'h00);
  endtask

  // Pin 3 through each sense code but SENSE_BUF_OFF; level set with sensing off, then driven again with it on
  task automatic t_sense;
    logic [2:0] cd [6] = '{SENSE_OFF, SENSE_BOTH, SENSE_RISE, SENSE_FALL,
                           SENSE_LOW, SENSE_LOW};
    logic       st [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic       en [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic       ex [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      wr(IDX_LINE_CONTROL + 6'h03, 8'h00);
      board[3] <= st[i];
      wt(4);
      wr(IDX_PIN_EVENT_FLAGS, 8'hff);
      wr(IDX_LINE_CONTROL + 6'h03, {5'h00, cd[i]});
      board[3] <= en[i];
      wt(4);
      rd(IDX_ALIAS_FLAGS, {4'h0, ex[i], 3'h0});
      chk({7'h0, port_irq}, {7'h0, ex[i]});
      if (cd[i] == SENSE_LOW) chk({7'h0, wake_req}, {7'h0, ~en[i]});
    end
    board[3] <= 1'b1;
    // Let the high level reach the sample, else low sensing re-sets
    wt(4);
    wr(IDX_PIN_EVENT_FLAGS, 8'h08);
    rd(IDX_PIN_EVENT_FLAGS, 8'h00);
    chk({7'h0, port_irq}, 8'h00);
  endtask

  task automatic t_polarity;
    wr(IDX_EVENT_SELECT, 8'h54);
    wr(IDX_LINE_CONTROL + 6'h04, 8'h01);
    wt(4);
    wr(IDX_PIN_EVENT_FLAGS, 8'hff);
    wr(IDX_LINE_CONTROL + 6'h04, 8'h81);
    wt(1);
    chk({6'h0, level_event}, 8'h03);
    wt(4);
    rd(IDX_PIN_EVENT_FLAGS, 8'h10);
  endtask

  task automatic t_reset_again;
    wr(IDX_DRIVE_ENABLE, 8'hff);
    presetn <= 1'b0;
    wt(2);
    chk(pad.drive_en, 8'h00);
    chk(pad.ibuf_en, 8'hff);
    presetn <= 1'b1;
    rd(IDX_LINE_CONTROL + 6'h04, 8'h00);
  endtask

  // Whole run is a few hundred cycles; allow ample margin
  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    board = 8'h00;
    tmpl_ext_wr = 1'b0;
    tmpl_ext_data = 8'h00;
    wt(16);
    chk(pad.drive_en, 8'h00);
    chk(pad.ibuf_en, 8'hff);
    presetn <= 1'b1;
    rd(IDX_DRIVE_LEVEL, 8'h00);
    t_dir;
    t_level;
    t_input;
    t_bufoff;
    t_lines;
    t_tmpl;
    t_sense;
    t_polarity;
    t_reset_again;
    end_of_test;
  end
endmodule
